// File: hdl/csp_port.sv
// System port pin logic of the processor: command/address channels,
// 64-bit data bus with check bits, forwarded clocks and valid strobes.
// Assumes every pin input is asynchronous; pins with the _n suffix use active-low levels.
`timescale 1ns/1ps
`default_nettype none
`include "csp_cfg.svh"

// Summary of operation
// R1: Framing reference clock edges frame the port
// R2: Inbound 15-bit multiplexed command channel received
// R3: Inbound forwarded clock captures command and fill
// R4: Device drives outbound 15-bit command channel
// R5: Device forwards clock with outbound channel
// R6: Data driver adds eight check bits
// R7: One bidirectional 64-bit bus both ways
// R8: Inbound data captured by eight forwarded clocks
// R9: Device generates eight outbound data clocks
// R10: Inbound data taken only when valid
// R11: Outbound data paced by system valid
// R12: Fill usable only after fill valid
// R13: Low-suffix pins are active low
module csp_port
   import csp_pkg::*;
(
   input  wire logic                  sys_clk_in,
   input  wire logic                  srst_in,
   input  wire logic                  framing_ref_clock_pos_in,
   input  wire logic                  framing_ref_clock_neg_in,
   input  wire csp_cmd_t              inbound_cmd_addr_bus_n_in,
   input  wire logic                  inbound_cmd_addr_fwd_clock_n_in,
   input  wire logic                  fill_valid_strobe_n_in,
   output logic [`CSP_CMD_W-1:0]      outbound_cmd_addr_bus_n_out,
   output logic                       outbound_cmd_addr_fwd_clock_n_out,
   input  wire logic [`CSP_DATA_W-1:0] port_data_bus_n_in,
   output logic [`CSP_DATA_W-1:0]     port_data_bus_n_out,
   output logic                       port_data_bus_oe_out,
   input  wire logic [`CSP_CHK_W-1:0] port_ecc_check_bits_n_in,
   output logic [`CSP_CHK_W-1:0]      port_ecc_check_bits_n_out,
   input  wire logic [`CSP_NFWD-1:0]  inbound_data_fwd_clocks_in,
   output logic [`CSP_NFWD-1:0]       outbound_data_fwd_clocks_n_out,
   input  wire logic                  inbound_data_valid_strobe_n_in,
   input  wire logic                  outbound_data_valid_strobe_n_in,
   input  wire csp_cmd_t              user_cmd_in,
   input  wire logic                  user_cmd_valid_in,
   output logic                       user_cmd_ready_out,
   input  wire csp_qword_t            user_wdata_in,
   input  wire logic                  user_wdata_valid_in,
   output logic                       user_wdata_ready_out,
   output csp_cmd_t                   user_rx_cmd_out,
   output logic                       user_rx_cmd_valid_out,
   output csp_qword_t                 user_rx_data_out,
   output logic                       user_rx_data_valid_out,
   output logic                       user_rx_ecc_err_out,
   output logic                       user_fill_usable_out,
   output logic                       frame_tick_out
);
   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   logic [`CSP_CMD_W-1:0]  cmd_m_reg, cmd_s_reg;
   logic [`CSP_DATA_W-1:0] dat_m_reg, dat_s_reg;
   logic [`CSP_CHK_W-1:0]  chk_m_reg, chk_s_reg;
   logic [2:0]             vld_m_reg, vld_s_reg;
   logic                   frm_rise, frm_neg_rise, cclk_rise;
   logic [`CSP_NFWD-1:0]   dclk_rise;

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         cmd_m_reg <= `CSP_IDLE_BUS;
         cmd_s_reg <= `CSP_IDLE_BUS;
         dat_m_reg <= '1;
         dat_s_reg <= '1;
         chk_m_reg <= '1;
         chk_s_reg <= '1;
         vld_m_reg <= 3'h7;
         vld_s_reg <= 3'h7;
      end else begin
         cmd_m_reg <= inbound_cmd_addr_bus_n_in;
         cmd_s_reg <= cmd_m_reg;
         dat_m_reg <= port_data_bus_n_in;
         dat_s_reg <= dat_m_reg;
         chk_m_reg <= port_ecc_check_bits_n_in;
         chk_s_reg <= chk_m_reg;
         vld_m_reg <= {fill_valid_strobe_n_in, inbound_data_valid_strobe_n_in, outbound_data_valid_strobe_n_in};
         vld_s_reg <= vld_m_reg;
      end
   end

   // Differential pair: both halves are watched, a frame starts when pos rises and neg falls in one cycle
   csp_sync_edge u_frm_p (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(framing_ref_clock_pos_in),
                          .level_out(), .rise_out(frm_rise), .fall_out());
   csp_sync_edge u_frm_n (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(framing_ref_clock_neg_in),
                          .level_out(), .rise_out(), .fall_out(frm_neg_rise));
   // Active-low forwarded clock: its falling pin edge is the capture edge
   csp_sync_edge u_cclk (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(inbound_cmd_addr_fwd_clock_n_in),
                         .level_out(), .rise_out(), .fall_out(cclk_rise)); // R13

   genvar g;
   generate
      for (g = 0; g < `CSP_NFWD; g++) begin : g_dclk
         csp_sync_edge u_dclk (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
                               .async_in(inbound_data_fwd_clocks_in[g]),
                               .level_out(), .rise_out(dclk_rise[g]), .fall_out());
      end
   endgenerate

   logic inv_n, outv_n, fillv_n;
   assign {fillv_n, inv_n, outv_n} = vld_s_reg;

   // -------------------------------------------------------------
   // Framing reference
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) frame_tick_out <= 1'b0;
      else         frame_tick_out <= frm_rise & frm_neg_rise; // R1
   end

   // -------------------------------------------------------------
   // Inbound command channel and fill validation
   // -------------------------------------------------------------
   logic fill_pend_reg;

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         user_rx_cmd_out       <= '0;
         user_rx_cmd_valid_out <= 1'b0;
      end else begin
         user_rx_cmd_valid_out <= cclk_rise; // R3
         if (cclk_rise) user_rx_cmd_out <= ~cmd_s_reg; // R2 R13
      end
   end

   // A fill arrives as an inbound data word; it is held back until the strobe and a command clock edge
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         fill_pend_reg        <= 1'b0;
         user_fill_usable_out <= 1'b0;
      end else begin
         user_fill_usable_out <= 1'b0;
         if (cclk_rise && !fillv_n && fill_pend_reg) begin
            user_fill_usable_out <= 1'b1; // R12
            fill_pend_reg        <= 1'b0;
         end
         // A word landing in the consuming cycle opens a new pending fill
         if (user_rx_data_valid_out) fill_pend_reg <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Inbound data with check
   // -------------------------------------------------------------
   logic [`CSP_DATA_W-1:0] rx_d;
   logic [`CSP_CHK_W-1:0]  rx_c;
   assign rx_d = ~dat_s_reg;
   assign rx_c = ~chk_s_reg;

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         user_rx_data_out       <= '0;
         user_rx_data_valid_out <= 1'b0;
         user_rx_ecc_err_out    <= 1'b0;
      end else begin
         // A rising edge on any forwarded clock counts; the lanes are skew matched
         user_rx_data_valid_out <= 1'b0;
         if (|dclk_rise && !inv_n && !port_data_bus_oe_out) begin // R8 R10
            user_rx_data_out       <= '{data: rx_d, check: rx_c};
            user_rx_data_valid_out <= 1'b1;
            user_rx_ecc_err_out    <= csp_ecc(rx_d) != rx_c; // R6
         end
      end
   end

   // -------------------------------------------------------------
   // Outbound command channel
   // -------------------------------------------------------------
   logic cdiv_reg;
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         cdiv_reg                          <= 1'b0;
         outbound_cmd_addr_bus_n_out       <= `CSP_IDLE_BUS;
         outbound_cmd_addr_fwd_clock_n_out <= 1'b1;
         user_cmd_ready_out                <= 1'b0;
      end else begin
         cdiv_reg                          <= ~cdiv_reg;
         outbound_cmd_addr_fwd_clock_n_out <= cdiv_reg; // R5
         user_cmd_ready_out                <= ~cdiv_reg;
         // Bus changes while clock pin goes high, stable over its fall
         if (cdiv_reg) begin
            if (user_cmd_valid_in && user_cmd_ready_out)
               outbound_cmd_addr_bus_n_out <= ~user_cmd_in; // R4 R13
            else
               outbound_cmd_addr_bus_n_out <= `CSP_IDLE_BUS;
         end
      end
   end

   // -------------------------------------------------------------
   // Outbound data, paced by system valid
   // -------------------------------------------------------------
   csp_out_state_t ost_reg;
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         ost_reg                        <= CSP_OUT_IDLE;
         port_data_bus_n_out            <= '1;
         port_ecc_check_bits_n_out      <= '1;
         port_data_bus_oe_out           <= 1'b0;
         outbound_data_fwd_clocks_n_out <= '1;
         user_wdata_ready_out           <= 1'b0;
      end else begin
         user_wdata_ready_out           <= 1'b0;
         outbound_data_fwd_clocks_n_out <= '1;
         unique case (ost_reg)
            CSP_OUT_IDLE: begin
               port_data_bus_oe_out <= 1'b0;
               if (!outv_n) begin
                  ost_reg              <= CSP_OUT_LOAD; // R11
                  user_wdata_ready_out <= 1'b1;
               end
            end
            CSP_OUT_LOAD: begin
               if (user_wdata_valid_in) begin
                  port_data_bus_n_out       <= ~user_wdata_in.data; // R7
                  port_ecc_check_bits_n_out <= ~csp_ecc(user_wdata_in.data); // R6
                  port_data_bus_oe_out      <= 1'b1;
                  ost_reg                   <= CSP_OUT_SEND;
               end else begin
                  ost_reg <= CSP_OUT_IDLE;
               end
            end
            CSP_OUT_SEND: begin
               outbound_data_fwd_clocks_n_out <= '0; // R9
               ost_reg                        <= CSP_OUT_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   a_fwd_clk_toggle: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R5
      outbound_cmd_addr_fwd_clock_n_out |=> !outbound_cmd_addr_fwd_clock_n_out)
      else $error("outbound command clock did not toggle");
   a_rx_only_valid: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R10
      user_rx_data_valid_out |-> $past(!inv_n))
      else $error("inbound data taken without valid strobe");
   a_out_paced: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R11
      $rose(port_data_bus_oe_out) |-> $past(!outv_n, 2))
      else $error("outbound data driven without system valid");
   a_data_clk_sent: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R9
      $rose(port_data_bus_oe_out) |=> outbound_data_fwd_clocks_n_out == '0 ##1 !port_data_bus_oe_out)
      else $error("outbound data clocks missing");
   a_out_ecc_ok: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R6
      port_data_bus_oe_out |-> csp_ecc(~port_data_bus_n_out) == ~port_ecc_check_bits_n_out)
      else $error("outbound check bits wrong");
   a_fill_after_strobe: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R12
      user_fill_usable_out |-> $past(!fillv_n && fill_pend_reg))
      else $error("fill usable without strobe");
   a_cmd_capture: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R3
      cclk_rise |=> user_rx_cmd_valid_out && user_rx_cmd_out == ~$past(cmd_s_reg))
      else $error("inbound command not captured");
   a_cmd_idle_high: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R4
      (cdiv_reg && !(user_cmd_valid_in && user_cmd_ready_out)) |=> outbound_cmd_addr_bus_n_out == `CSP_IDLE_BUS)
      else $error("outbound command bus not idle");
   a_cmd_drive: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R4
      (cdiv_reg && user_cmd_valid_in && user_cmd_ready_out) |=> outbound_cmd_addr_bus_n_out == ~$past(user_cmd_in))
      else $error("outbound command not driven");
endmodule // csp_port

`default_nettype wire

// File: hdl/csp_cfg.svh
// Constants for the processor system port pin logic.
// Assumes inclusion by the package and design modules by bare name.
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

`define CSP_CMD_W        15
`define CSP_DATA_W       64
`define CSP_CHK_W        8
`define CSP_NFWD         8
`define CSP_OUT_DIV      2
`define CSP_IDLE_BUS     15'h7FFF

`endif

// File: hdl/csp_pkg.sv
// Types shared by the system port pin logic.
// Assumes csp_cfg.svh is on the include path.
`include "csp_cfg.svh"

package csp_pkg;
   typedef logic [`CSP_CMD_W-1:0] csp_cmd_t;

   typedef struct packed {
      logic [`CSP_DATA_W-1:0] data;
      logic [`CSP_CHK_W-1:0]  check;
   } csp_qword_t;

   typedef enum logic [1:0] {CSP_OUT_IDLE, CSP_OUT_LOAD, CSP_OUT_SEND} csp_out_state_t;

   // Check bits: each bit is the parity of an interleaved byte lane slice
   function automatic logic [`CSP_CHK_W-1:0] csp_ecc(input logic [`CSP_DATA_W-1:0] d);
      logic [`CSP_CHK_W-1:0] c;
      c = '0;
      for (int i = 0; i < `CSP_DATA_W; i++) begin
         c[i % `CSP_CHK_W] = c[i % `CSP_CHK_W] ^ d[i];
      end
      return c;
   endfunction
endpackage

// File: hdl/csp_sync_edge.sv
// Two-flop synchroniser with rising and falling edge detection.
// Assumes input is asynchronous to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none

module csp_sync_edge (
   input  wire logic sys_clk_in,
   input  wire logic srst_in,
   input  wire logic async_in,
   output logic      level_out,
   output logic      rise_out,
   output logic      fall_out
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level_out = sync_reg;
   assign rise_out  = sync_reg & ~last_reg;
   assign fall_out  = ~sync_reg & last_reg;
endmodule // csp_sync_edge

`default_nettype wire

// File: verif/csp_sys_model.sv
// System-side model of the port: drives the inbound pins and captures outbound traffic.
// Assumes the bench resolves the open-drain data and check lines by wired AND.
`timescale 1ns/1ps
`default_nettype none
`include "csp_cfg.svh"
module csp_sys_model
   import csp_pkg::*;
(
   output logic             frm_p_out,
   output logic             frm_n_out,
   output csp_cmd_t         cmd_n_out,
   output logic             cmd_clk_n_out,
   output logic             fill_n_out,
   output logic [63:0]      dat_n_out,
   output logic [7:0]       chk_n_out,
   output logic             drv_out,
   output logic [7:0]       dclk_out,
   output logic             in_vld_n_out,
   output logic             out_vld_n_out,
   input  wire csp_cmd_t    ocmd_n_in,
   input  wire logic        ocmd_clk_n_in,
   input  wire logic [63:0] dat_n_in,
   input  wire logic [7:0]  chk_n_in,
   input  wire logic [7:0]  oclk_n_in
);
   csp_cmd_t   cmd_q[$];
   csp_qword_t word_q[$];
   logic [7:0] lane_q[$];

   initial begin
      {frm_p_out, frm_n_out, cmd_clk_n_out, fill_n_out} = 4'h7;
      cmd_n_out = 15'h7FFF;
      {dat_n_out, chk_n_out} = '1;
      {drv_out, dclk_out} = 9'h000;
      {in_vld_n_out, out_vld_n_out} = 2'h3;
   end
   // ----------------------------------------------------------------
   // Inbound traffic; forwarded clocks stand still between frames
   // ----------------------------------------------------------------
   task automatic send_cmd(input csp_cmd_t c);
      cmd_n_out = ~c;
      #100 cmd_clk_n_out = 1'h0;
      #100 cmd_clk_n_out = 1'h1;
      cmd_n_out = c;  // Released bus shows the inverse, not a stale copy
   endtask
   task automatic send_data(input csp_qword_t q, input logic vld);
      {dat_n_out, chk_n_out} = ~q;
      drv_out = 1'h1;
      in_vld_n_out = ~vld;
      #100 dclk_out = 8'hFF;
      #100 dclk_out = 8'h00;
      in_vld_n_out = 1'h1;
      drv_out = 1'h0;
   endtask
   task automatic fill();
      fill_n_out = 1'h0;
      #100 cmd_clk_n_out = 1'h0;
      #100 cmd_clk_n_out = 1'h1;
      fill_n_out = 1'h1;
   endtask
   task automatic out_valid(input logic on);
      out_vld_n_out = ~on;
   endtask
   task automatic frames(input int n);
      repeat (n) begin
         {frm_p_out, frm_n_out} = 2'h2;
         #100 {frm_p_out, frm_n_out} = 2'h1;
         #100;
      end
      {frm_p_out, frm_n_out} = 2'h1;
   endtask
   // ----------------------------------------------------------------
   // Outbound capture; idle command words are not queued
   // ----------------------------------------------------------------
   always @(negedge ocmd_clk_n_in) begin
      if (ocmd_n_in !== `CSP_IDLE_BUS) cmd_q.push_back(~ocmd_n_in);
   end
   always @(negedge oclk_n_in[0]) begin
      #1;
      word_q.push_back(~{dat_n_in, chk_n_in});
      lane_q.push_back(oclk_n_in);
   end
endmodule // csp_sys_model
`default_nettype wire

// File: verif/tb_cpu_system_port_pins.sv
// Self-checking bench for the system port pin logic with a system-side model.
// Assumes the port and its package compile first; open-drain lines resolve here.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_system_port_pins;
   import csp_pkg::*;
   localparam logic [63:0] OUT_D = 64'hFEDCBA9876543210;
   logic             sys_clk_in, srst_in, user_cmd_valid_in, user_wdata_valid_in, rx_err;
   csp_cmd_t         user_cmd_in, rx_cmd;
   csp_qword_t       user_wdata_in, rx_q;
   wire logic        framing_ref_clock_pos_in, framing_ref_clock_neg_in, inbound_cmd_addr_fwd_clock_n_in;
   wire logic        fill_valid_strobe_n_in, inbound_data_valid_strobe_n_in, outbound_data_valid_strobe_n_in;
   wire logic        outbound_cmd_addr_fwd_clock_n_out, port_data_bus_oe_out, user_cmd_ready_out, sys_drv;
   wire logic        user_wdata_ready_out, user_rx_cmd_valid_out, user_rx_data_valid_out, user_rx_ecc_err_out;
   wire logic        user_fill_usable_out, frame_tick_out;
   wire csp_cmd_t    inbound_cmd_addr_bus_n_in, outbound_cmd_addr_bus_n_out, user_rx_cmd_out;
   wire csp_qword_t  user_rx_data_out;
   wire logic [63:0] port_data_bus_n_in, port_data_bus_n_out, sys_dat;
   wire logic [7:0]  port_ecc_check_bits_n_in, port_ecc_check_bits_n_out, sys_chk;
   wire logic [7:0]  inbound_data_fwd_clocks_in, outbound_data_fwd_clocks_n_out;
   int               mismatches, cmp_count, cyc, rx_cmd_n, rx_dat_n, fill_n, tick_n, rdy_n;

   // Open-drain lines: any driver pulls low, released lines float high
   assign port_data_bus_n_in = (port_data_bus_oe_out ? port_data_bus_n_out : '1) & (sys_drv ? sys_dat : '1);
   assign port_ecc_check_bits_n_in = (port_data_bus_oe_out ? port_ecc_check_bits_n_out : '1) & (sys_drv ? sys_chk : '1);

   csp_port dut_u (.sys_clk_in, .srst_in, .framing_ref_clock_pos_in, .framing_ref_clock_neg_in,
      .inbound_cmd_addr_bus_n_in, .inbound_cmd_addr_fwd_clock_n_in, .fill_valid_strobe_n_in,
      .outbound_cmd_addr_bus_n_out, .outbound_cmd_addr_fwd_clock_n_out, .port_data_bus_n_in, .port_data_bus_n_out,
      .port_data_bus_oe_out, .port_ecc_check_bits_n_in, .port_ecc_check_bits_n_out, .inbound_data_fwd_clocks_in,
      .outbound_data_fwd_clocks_n_out, .inbound_data_valid_strobe_n_in, .outbound_data_valid_strobe_n_in,
      .user_cmd_in, .user_cmd_valid_in, .user_cmd_ready_out, .user_wdata_in, .user_wdata_valid_in,
      .user_wdata_ready_out, .user_rx_cmd_out, .user_rx_cmd_valid_out, .user_rx_data_out,
      .user_rx_data_valid_out, .user_rx_ecc_err_out, .user_fill_usable_out, .frame_tick_out);
   csp_sys_model sys_u (.frm_p_out(framing_ref_clock_pos_in), .frm_n_out(framing_ref_clock_neg_in),
      .cmd_n_out(inbound_cmd_addr_bus_n_in), .cmd_clk_n_out(inbound_cmd_addr_fwd_clock_n_in),
      .fill_n_out(fill_valid_strobe_n_in), .dat_n_out(sys_dat), .chk_n_out(sys_chk), .drv_out(sys_drv),
      .dclk_out(inbound_data_fwd_clocks_in), .in_vld_n_out(inbound_data_valid_strobe_n_in),
      .out_vld_n_out(outbound_data_valid_strobe_n_in), .ocmd_n_in(outbound_cmd_addr_bus_n_out),
      .ocmd_clk_n_in(outbound_cmd_addr_fwd_clock_n_out), .dat_n_in(port_data_bus_n_in),
      .chk_n_in(port_ecc_check_bits_n_in), .oclk_n_in(outbound_data_fwd_clocks_n_out));

   initial begin
      sys_clk_in = 1'h0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   // ----------------------------------------------------------------
   // Monitors and hang limit
   // ----------------------------------------------------------------
   always @(posedge sys_clk_in) begin
      cyc++;
      if (user_rx_cmd_valid_out === 1'h1) begin
         rx_cmd_n++;
         rx_cmd = user_rx_cmd_out;
      end
      if (user_rx_data_valid_out === 1'h1) begin
         rx_dat_n++;
         rx_q = user_rx_data_out;
         rx_err = user_rx_ecc_err_out;
      end
      fill_n += int'(user_fill_usable_out === 1'h1);
      tick_n += int'(frame_tick_out === 1'h1);
      rdy_n += int'(user_wdata_ready_out === 1'h1);
      if (cyc == 20000) begin
         mismatches++;
         results();
      end
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] ecc_of(input logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 64; i++) c[i % 8] ^= d[i];
      return c;
   endfunction
   task automatic tick();
      @(posedge sys_clk_in);
      #1;
   endtask
   task automatic bad(input string m);
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic cmp_cmd(input csp_cmd_t got, exp, input string m);
      cmp_count++;
      if (got !== exp) bad(m);
   endtask
   task automatic cmp_word(input csp_qword_t got, exp, input string m);
      cmp_count++;
      if (got !== exp) bad(m);
   endtask
   task automatic cmp_bit(input logic got, exp, input string m);
      cmp_count++;
      if (got !== exp) bad(m);
   endtask
   task automatic cmp_cnt(input int got, exp, input string m);
      cmp_count++;
      if (got != exp) bad(m);
   endtask
   task automatic push_cmd(input csp_cmd_t c);
      user_cmd_in = c;
      user_cmd_valid_in = 1'h1;
      for (int k = 0; k < 20 && user_cmd_ready_out !== 1'h1; k++) tick();
      tick();
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      cmp_cmd(outbound_cmd_addr_bus_n_out, 15'h7FFF, "command bus not idle");
      cmp_bit(port_data_bus_oe_out, 1'h0, "data bus driven after reset");
      cmp_bit(&outbound_data_fwd_clocks_n_out, 1'h1, "data clocks not idle");
   endtask
   task automatic t_cmd_out();
      sys_u.cmd_q.delete();
      push_cmd(15'h1234);
      push_cmd(15'h4ABC);
      user_cmd_valid_in = 1'h0;
      for (int k = 0; k < 20 && sys_u.cmd_q.size() < 2; k++) tick();
      cmp_cnt(sys_u.cmd_q.size(), 2, "outbound command count");
      cmp_cmd(sys_u.cmd_q[0], 15'h1234, "first outbound command");
      cmp_cmd(sys_u.cmd_q[1], 15'h4ABC, "second outbound command");
   endtask
   task automatic t_cmd_in();
      int k0;
      k0 = rx_cmd_n;
      sys_u.send_cmd(15'h2D5A);
      for (int k = 0; k < 40 && rx_cmd_n == k0; k++) tick();
      cmp_cmd(rx_cmd, 15'h2D5A, "inbound command");
   endtask
   task automatic t_data_in();
      csp_qword_t q;
      int         k0;
      q = {64'h0123456789ABCDEF, ecc_of(64'h0123456789ABCDEF)};
      for (int n = 0; n < 2; n++) begin
         k0 = rx_dat_n;
         sys_u.send_data(q, 1'h1);
         for (int k = 0; k < 40 && rx_dat_n == k0; k++) tick();
         cmp_word(rx_q, q, "inbound word");
         cmp_bit(rx_err, n[0], "check bit verdict");
         q.check ^= 8'h10;
      end
      k0 = rx_dat_n;
      sys_u.send_data(~q, 1'h0);
      repeat (20) tick();
      cmp_cnt(rx_dat_n - k0, 0, "unmarked word accepted");
      k0 = fill_n;
      sys_u.fill();
      for (int k = 0; k < 40 && fill_n == k0; k++) tick();
      cmp_cnt(fill_n - k0, 1, "fill not usable");
   endtask
   task automatic t_data_out();
      int k0;
      user_wdata_in = {OUT_D, 8'h00};
      user_wdata_valid_in = 1'h1;
      sys_u.word_q.delete();
      sys_u.lane_q.delete();
      k0 = rdy_n;
      repeat (20) tick();
      cmp_cnt(rdy_n - k0, 0, "sent without outbound strobe");
      sys_u.out_valid(1'h1);
      for (int k = 0; k < 20 && user_wdata_ready_out !== 1'h1; k++) tick();
      sys_u.out_valid(1'h0);
      tick();
      user_wdata_valid_in = 1'h0;
      for (int k = 0; k < 20 && sys_u.word_q.size() == 0; k++) tick();
      cmp_word(sys_u.word_q[0], {OUT_D, ecc_of(OUT_D)}, "outbound word");
      cmp_bit(sys_u.lane_q[0] === 8'h00, 1'h1, "data clocks not together");
   endtask
   task automatic t_frames();
      int k0;
      k0 = tick_n;
      sys_u.frames(10);
      repeat (10) tick();
      cmp_cnt(tick_n - k0, 10, "frame ticks");
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      srst_in = 1'h1;
      {user_cmd_in, user_cmd_valid_in, user_wdata_in, user_wdata_valid_in} = '0;
      repeat (12) tick();
      srst_in = 1'h0;
      repeat (2) tick();
      t_reset();
      t_cmd_out();
      t_cmd_in();
      t_data_in();
      t_data_out();
      t_frames();
      results();
   end
endmodule // tb_cpu_system_port_pins
`default_nettype wire
